// File: rtl/mesd_decode.v
// extended front-end state decoder: remap table, scoreboard and descriptor fields
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mesd_defs.vh"
module mesd_decode #(
	parameter OFS_W = 7
) (
	input wire mclk,
	input wire rstn,
	input wire ptr_load,
	input wire ext_state_en,
	input wire [3:0] front_end_mode,
	input wire [1:0] picture_structure,
	input wire state_we,
	input wire [2:0] state_addr,
	input wire [31:0] state_wdata,
	input wire cmd_valid,
	input wire [OFS_W-1:0] cmd_desc_ofs,
	input wire cmd_mv_zero,
	input wire desc_valid,
	input wire [31:0] desc_word0,
	input wire [31:0] desc_word1,
	input wire reg_wr,
	input wire reg_rd,
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	output reg [31:0] reg_rdata,
	output reg disp_valid,
	output reg [OFS_W-1:0] disp_desc_idx,
	output reg [4:0] disp_wo_ofs,
	output reg [4:0] disp_res_ofs,
	output reg [7:0] disp_res_fixed_dw,
	output reg disp_res_fixed,
	output reg [1:0] disp_subfields,
	output reg sb_enable,
	output reg sb_nonstall,
	output reg [7:0] sb_mask,
	output reg [63:0] sb_deltas,
	output reg kern_valid,
	output reg [25:0] kern_start,
	output reg [4:0] kern_blocks,
	output reg const_load,
	output reg [5:0] const_len,
	output reg [5:0] const_ofs
);

////////////////////////////////////////////////////////////////////////////////
// stored state words

reg ext_sel_r;
reg [3:0] mode_r;
reg [1:0] pstruct_r;
reg [31:0] ctrl_r;
reg [31:0] remap_lo_r;
reg [31:0] remap_hi_r;
reg [31:0] sb_ctrl_r;
reg [31:0] sb_dlo_r;
reg [31:0] sb_dhi_r;
reg [31:0] disp_count_r;

// nibble n mod 8 of the chosen remap word
function [3:0] pick_nibble;
	input [31:0] w;
	input [2:0] n;
	begin
		pick_nibble = w[{n, 2'b00} +: 4]; // [R1]
	end
endfunction

function is_h264;
	input [3:0] m;
	begin
		is_h264 = (m == `MESD_MODE_H264_MC) || (m == `MESD_MODE_H264_IT); // [R20]
	end
endfunction

always @(posedge mclk) begin
	if (!rstn) begin
		ext_sel_r <= 1'b0;
		mode_r <= 4'h0;
		pstruct_r <= `MESD_PS_FRAME;
		ctrl_r <= `MESD_WORD_RST;
		remap_lo_r <= `MESD_WORD_RST;
		remap_hi_r <= `MESD_WORD_RST;
		sb_ctrl_r <= `MESD_WORD_RST;
		sb_dlo_r <= `MESD_WORD_RST;
		sb_dhi_r <= `MESD_WORD_RST;
	end else begin
		if (ptr_load) begin
			ext_sel_r <= ext_state_en; // [R19] [R3]
			mode_r <= front_end_mode;
			pstruct_r <= picture_structure;
		end
		if (state_we) begin
			case (state_addr)
			`MESD_W_CTRL: ctrl_r <= state_wdata;
			`MESD_W_REMAP_LO: remap_lo_r <= state_wdata;
			`MESD_W_REMAP_HI: remap_hi_r <= state_wdata;
			`MESD_W_SB_CTRL: sb_ctrl_r <= state_wdata;
			`MESD_W_SB_DLO: sb_dlo_r <= state_wdata;
			`MESD_W_SB_DHI: sb_dhi_r <= state_wdata;
			default: ;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// descriptor offset remap

reg [OFS_W-1:0] idx_nxt;
reg [3:0] nib;
always @* begin
	nib = cmd_desc_ofs[3] ? pick_nibble(remap_hi_r, cmd_desc_ofs[2:0]) :
		pick_nibble(remap_lo_r, cmd_desc_ofs[2:0]); // [R1]
	idx_nxt = cmd_desc_ofs;
	// upper half only meaningful for frame destinations
	if (ext_sel_r && cmd_desc_ofs <= `MESD_REMAP_LAST) begin // [R2] [R3]
		if (!cmd_desc_ofs[3] || pstruct_r == `MESD_PS_FRAME) // [R4]
			idx_nxt = {{(OFS_W-4){1'b0}}, nib};
	end
end

////////////////////////////////////////////////////////////////////////////////
// control word and dispatch

wire ctl_ok = ext_sel_r && is_h264(mode_r); // [R5]
wire [31:0] ctl = ctl_ok ? ctrl_r : `MESD_WORD_RST; // [R5]
wire fixed = ctl[`MESD_FIXOFS_BIT]; // [R10]
wire [1:0] subf = ctl[`MESD_SUBF_HI:`MESD_SUBF_LO]; // [R11]
wire vec_ok = subf[0]; // 00 none, 01 vectors, 11 both; 10 treated as none

always @(posedge mclk) begin
	if (!rstn) begin
		disp_valid <= 1'b0;
		disp_desc_idx <= {OFS_W{1'b0}};
		disp_wo_ofs <= 5'h0;
		disp_res_ofs <= 5'h0;
		disp_res_fixed_dw <= 8'h00;
		disp_res_fixed <= 1'b0;
		disp_subfields <= 2'h0;
		disp_count_r <= `MESD_WORD_RST;
	end else begin
		disp_valid <= cmd_valid;
		if (cmd_valid) begin
			disp_desc_idx <= idx_nxt; // [R21]
			disp_count_r <= disp_count_r + 32'h0000_0001;
			disp_subfields <= subf; // [R11]
			disp_res_fixed <= fixed; // [R10]
			// fixed offset only counts with its flag set
			disp_res_fixed_dw <= fixed ? ctl[`MESD_RESOFS_HI:`MESD_RESOFS_LO] : 8'h00; // [R12]
			// zero-vector blocks: weights ignored, residual at start of indirect data
			disp_wo_ofs <= (cmd_mv_zero || !vec_ok) ? 5'h0 :
				ctl[`MESD_WOOFS_HI:`MESD_WOOFS_LO]; // [R13]
			disp_res_ofs <= cmd_mv_zero ? 5'h0 : ctl[`MESD_INTOFS_HI:`MESD_INTOFS_LO]; // [R14]
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// scoreboard, gated by its enable

always @(posedge mclk) begin
	if (!rstn) begin
		sb_enable <= 1'b0;
		sb_nonstall <= 1'b0;
		sb_mask <= 8'h00;
		sb_deltas <= 64'h0000_0000_0000_0000;
	end else begin
		sb_enable <= ext_sel_r && sb_ctrl_r[`MESD_SB_EN_BIT]; // [R6]
		if (ext_sel_r && sb_ctrl_r[`MESD_SB_EN_BIT]) begin // [R6]
			sb_nonstall <= sb_ctrl_r[`MESD_SB_TYPE_BIT]; // [R7]
			sb_mask <= sb_ctrl_r[7:0]; // [R8]
			sb_deltas <= {sb_dhi_r, sb_dlo_r}; // [R9]
		end else begin
			sb_nonstall <= 1'b0;
			sb_mask <= 8'h00;
			sb_deltas <= 64'h0000_0000_0000_0000;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// kernel descriptor leading fields

always @(posedge mclk) begin
	if (!rstn) begin
		kern_valid <= 1'b0;
		kern_start <= 26'h000_0000;
		kern_blocks <= 5'h00;
		const_load <= 1'b0;
		const_len <= 6'h00;
		const_ofs <= 6'h00;
	end else begin
		kern_valid <= desc_valid;
		if (desc_valid) begin
			kern_start <= desc_word0[`MESD_KSTART_HI:`MESD_KSTART_LO]; // [R15]
			// stored as count minus one; one is added to the whole 4-bit field
			kern_blocks <= {1'b0, desc_word0[`MESD_GRFBLK_HI:0]} + 5'h01; // [R16]
			const_len <= desc_word1[`MESD_CLEN_HI:`MESD_CLEN_LO]; // [R17]
			const_load <= |desc_word1[`MESD_CLEN_HI:`MESD_CLEN_LO]; // [R17]
			const_ofs <= (|desc_word1[`MESD_CLEN_HI:`MESD_CLEN_LO]) ?
				desc_word1[`MESD_COFS_HI:`MESD_COFS_LO] : 6'h00; // [R18] [R17]
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// register port: index 1-6 state words, 8 status, 9 dispatch count; others read zero

always @(posedge mclk) begin
	if (!rstn) begin
		reg_rdata <= `MESD_WORD_RST;
	end else if (reg_rd) begin
		case (reg_addr)
		4'h1: reg_rdata <= ctrl_r;
		4'h2: reg_rdata <= remap_lo_r;
		4'h3: reg_rdata <= remap_hi_r;
		4'h4: reg_rdata <= sb_ctrl_r;
		4'h5: reg_rdata <= sb_dlo_r;
		4'h6: reg_rdata <= sb_dhi_r;
		4'h8: reg_rdata <= {25'h000_0000, ctl_ok, pstruct_r, mode_r};
		4'h9: reg_rdata <= disp_count_r;
		default: reg_rdata <= `MESD_WORD_RST;
		endcase
	end
end

// writes over the register port are accepted but ignored; unused here
wire unused_wr = reg_wr & (|reg_wdata);

endmodule
`default_nettype wire

// File: rtl/mesd_defs.vh
// constants for the extended front-end state decoder
// How it works
// [R1] sixteen 4-bit remap entries, nibble n mod 8 of word two or three
// [R2] descriptor offsets above 15 pass through without lookup
// [R3] remap only when extended state selected, else offset used directly
// [R4] field destinations use only the lower eight remap entries
// [R5] control word decoded only in h264 modes; alternate transform mode reads zero
// [R6] scoreboard enable bit 31; when clear type, mask and deltas ignored
// [R7] bit 30 scoreboard type, 0 stalling, 1 non-stalling
// [R8] mask bits 7:0 enable dependency checks 0 to 7
// [R9] signed 4-bit y/x deltas per byte, y upper nibble
// [R10] bit 26 selects fixed residual offset versus packed after vectors
// [R11] bits 25:24 say which indirect sub-fields exist
// [R12] bits 23:16 fixed residual offset in dwords, used only with flag
// [R13] bits 12:8 weight/offset register offset, ignored for zero-vector blocks
// [R14] bits 4:0 residual register offset; intra blocks start at zero
// [R15] descriptor word 0 bits 31:6 give 64-byte aligned kernel start
// [R16] bits 3:0 register blocks minus one, 1 to 16 blocks
// [R17] word 1 bits 31:26 constant read length; zero suppresses load and offset
// [R18] word 1 bits 25:20 constant read offset in 8-dword units
// [R19] state pointer bit 0 says whether extended state is loaded
// [R20] mode 0100 is h264 motion comp, 0111 is h264 inverse transform
// [R21] final offset indexes the descriptor array for dispatch
`ifndef MESD_DEFS_VH
`define MESD_DEFS_VH
`define MESD_W_CTRL 3'h1
`define MESD_W_REMAP_LO 3'h2
`define MESD_W_REMAP_HI 3'h3
`define MESD_W_SB_CTRL 3'h4
`define MESD_W_SB_DLO 3'h5
`define MESD_W_SB_DHI 3'h6
`define MESD_SB_EN_BIT 31
`define MESD_SB_TYPE_BIT 30
`define MESD_FIXOFS_BIT 26
`define MESD_SUBF_HI 25
`define MESD_SUBF_LO 24
`define MESD_RESOFS_HI 23
`define MESD_RESOFS_LO 16
`define MESD_WOOFS_HI 12
`define MESD_WOOFS_LO 8
`define MESD_INTOFS_HI 4
`define MESD_INTOFS_LO 0
`define MESD_KSTART_HI 31
`define MESD_KSTART_LO 6
`define MESD_GRFBLK_HI 3
`define MESD_CLEN_HI 31
`define MESD_CLEN_LO 26
`define MESD_COFS_HI 25
`define MESD_COFS_LO 20
`define MESD_MODE_H264_MC 4'h4
`define MESD_MODE_H264_IT 4'h7
`define MESD_MODE_ALT_IT 4'hb
`define MESD_PS_FRAME 2'h3
`define MESD_REMAP_LAST 7'h0f
`define MESD_WORD_RST 32'h0000_0000
`endif

// File: tb/mesd_cs.sv
// partner model: command streamer loading state and issuing commands
`timescale 1ns/1ps
`default_nettype none
module mesd_cs (
	input wire logic mclk,
	output logic ptr_load,
	output logic ext_state_en,
	output logic [3:0] front_end_mode,
	output logic [1:0] picture_structure,
	output logic state_we,
	output logic [2:0] state_addr,
	output logic [31:0] state_wdata,
	output logic cmd_valid,
	output logic [6:0] cmd_desc_ofs,
	output logic cmd_mv_zero,
	output logic desc_valid,
	output logic [31:0] desc_word0,
	output logic [31:0] desc_word1
);
	initial {ptr_load, ext_state_en, front_end_mode, picture_structure, state_we, state_addr,
		state_wdata, cmd_valid, cmd_desc_ofs, cmd_mv_zero, desc_valid, desc_word0, desc_word1} = '0;
	// pointer bit 0 says whether extended state is in use
	task ptr(input logic e, input logic [3:0] m, input logic [1:0] s);
		@(posedge mclk);
		{ptr_load, ext_state_en, front_end_mode, picture_structure} <= {1'b1, e, m, s};
		@(posedge mclk);
		ptr_load <= 0;
	endtask
	// callers keep type 0, fixed flag 1 in motion comp, zero unused offsets
	task wst(input logic [2:0] a, input logic [31:0] d);
		@(posedge mclk);
		{state_we, state_addr, state_wdata} <= {1'b1, a, d};
		@(posedge mclk);
		{state_we, state_wdata} <= {1'b0, ~d};
	endtask
	// released data lines except cmd_mv_zero show the inverse so stale values never look valid
	task cmd(input logic [6:0] o, input logic z);
		@(posedge mclk);
		{cmd_valid, cmd_desc_ofs, cmd_mv_zero} <= {1'b1, o, z};
		@(posedge mclk);
		{cmd_valid, cmd_desc_ofs} <= {1'b0, ~o};
	endtask
	// block count lsb kept zero by callers
	task desc(input logic [31:0] w0, input logic [31:0] w1);
		@(posedge mclk);
		{desc_valid, desc_word0, desc_word1} <= {1'b1, w0, w1};
		@(posedge mclk);
		{desc_valid, desc_word0, desc_word1} <= {1'b0, ~w0, ~w1};
	endtask
endmodule
`default_nettype wire

// File: tb/mesd_decode_bench.sv
// self-checking bench for the extended front-end state decoder
`timescale 1ns/1ps
`default_nettype none
module mesd_decode_bench;
	logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
	logic [3:0] reg_addr = 0, front_end_mode;
	logic [31:0] reg_wdata = 0, reg_rdata, state_wdata, desc_word0, desc_word1;
	logic ptr_load, ext_state_en, state_we, cmd_valid, cmd_mv_zero, desc_valid, disp_valid;
	logic [1:0] picture_structure, disp_subfields;
	logic [2:0] state_addr;
	logic [6:0] cmd_desc_ofs, disp_desc_idx;
	logic [4:0] disp_wo_ofs, disp_res_ofs, kern_blocks;
	logic [7:0] disp_res_fixed_dw, sb_mask;
	logic disp_res_fixed, sb_enable, sb_nonstall, kern_valid, const_load;
	logic [63:0] sb_deltas;
	logic [25:0] kern_start;
	logic [5:0] const_len, const_ofs;
	int bad_count = 0, checks_done = 0;
	always #2 mclk = ~mclk;
	mesd_decode dut (.*);
	mesd_cs cs (.*);
	task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge mclk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge mclk);
		reg_rd <= 0;
		#1 chk(reg_rdata, e, "read");
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#20000 bad_count++;
		summarize;
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1;
		#1 chk(sb_enable, 0, "reset sb");
		cs.wst(3'h2, 32'h0123_4567);
		cs.wst(3'h3, 32'h89ab_cdef);
		cs.ptr(0, 4'h4, 2'h3);
		cs.cmd(7'h3, 0);
		#1 chk(disp_desc_idx, 3, "bypass");
		cs.ptr(1, 4'h4, 2'h3);
		for (int i = 0; i < 16; i++) begin
			cs.cmd(i[6:0], 0);
			#1 chk(disp_desc_idx, 7 - i % 8 + (i < 8 ? 0 : 8), "remap");
		end
		cs.cmd(7'h14, 0);
		#1 chk(disp_desc_idx, 7'h14, "passthru");
		$display("test done: remap");
		cs.ptr(1, 4'h4, 2'h1);
		cs.cmd(7'h2, 0);
		#1 chk(disp_desc_idx, 5, "field lo");
		cs.cmd(7'h9, 0);
		#1 chk(disp_desc_idx, 9, "field hi");
		cs.wst(3'h1, 32'h0720_0308);
		cs.cmd(7'h0, 0);
		#1 chk({disp_res_fixed, disp_subfields, disp_res_fixed_dw}, 11'h720, "ctl");
		chk({disp_wo_ofs, disp_res_ofs}, {5'h3, 5'h8}, "ofs");
		cs.cmd(7'h0, 1);
		#1 chk(disp_res_ofs, 0, "intra");
		cs.ptr(1, 4'hb, 2'h3);
		cs.cmd(7'h0, 0);
		#1 chk({disp_res_fixed, disp_res_fixed_dw}, 0, "alt mode");
		$display("test done: control");
		cs.wst(3'h4, 32'h8000_00a5);
		cs.wst(3'h5, 32'hf1e2_d3c4);
		cs.wst(3'h6, 32'h7f80_1122);
		// gated scoreboard copy trails the word latch by one edge
		@(posedge mclk);
		#1 chk({sb_enable, sb_nonstall, sb_mask}, 10'h2a5, "sb");
		chk(sb_deltas, 64'h7f80_1122_f1e2_d3c4, "deltas");
		rd(4'h5, 32'hf1e2_d3c4);
		rd(4'h2, 32'h0123_4567);
		rd(4'hf, 0);
		@(posedge mclk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, 4'h2, 32'h5555_aaaa};
		@(posedge mclk);
		reg_wr <= 0;
		rd(4'h2, 32'h0123_4567);
		cs.wst(3'h4, 32'h0000_00ff);
		@(posedge mclk);
		#1 chk(sb_enable, 0, "sb off");
		chk({sb_mask, sb_deltas}, 72'h0, "sb off fields");
		$display("test done: scoreboard");
		cs.desc(32'hffff_ffc6, 32'h03f0_0000);
		#1 chk({kern_start, kern_blocks, const_load}, {26'h3ff_ffff, 5'h7, 1'b0}, "k0");
		cs.desc(32'h0000_0040, 32'hfc50_0000);
		#1 chk({kern_blocks, const_load, const_len, const_ofs}, {5'h1, 1'b1, 6'h3f, 6'h5}, "k1");
		$display("test done: descriptor");
		summarize;
	end
endmodule
`default_nettype wire

// File: tb/mesd_props.sv
// checker for the extended front-end state decoder
`timescale 1ns/1ps
`default_nettype none
module mesd_props #(parameter OFS_W = 7) (
	input wire mclk,
	input wire rstn,
	input wire logic ptr_load,
	input wire logic ext_state_en,
	input wire state_we,
	input wire [2:0] state_addr,
	input wire [31:0] state_wdata,
	input wire cmd_valid,
	input wire [OFS_W-1:0] cmd_desc_ofs,
	input wire desc_valid,
	input wire [31:0] desc_word0,
	input wire [31:0] desc_word1,
	input wire disp_valid,
	input wire [OFS_W-1:0] disp_desc_idx,
	input wire sb_enable,
	input wire sb_nonstall,
	input wire [7:0] sb_mask,
	input wire [63:0] sb_deltas,
	input wire kern_valid,
	input wire [25:0] kern_start,
	input wire [4:0] kern_blocks,
	input wire const_load,
	input wire [5:0] const_len,
	input wire [5:0] const_ofs
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire sb_wr = state_we && state_addr == 3'h4;
	// shadow of the extended-state selection, so scoreboard gating can be predicted
	logic ext_seen;
	always @(posedge mclk) begin
		if (!rstn) ext_seen <= 1'b0;
		else if (ptr_load) ext_seen <= ext_state_en;
	end
	property p_disp; cmd_valid |=> disp_valid ##1 !disp_valid || $past(cmd_valid); endproperty
	a_disp: assert property (p_disp) else $error("dispatch pulse wrong");
	property p_pass; cmd_valid && cmd_desc_ofs > 15 |=> disp_desc_idx == $past(cmd_desc_ofs); endproperty
	a_pass: assert property (p_pass) else $error("large offset remapped");
	property p_kst; desc_valid |=> kern_valid && kern_start == $past(desc_word0[31:6]); endproperty
	a_kst: assert property (p_kst) else $error("kernel start wrong");
	property p_blk; desc_valid |=> kern_blocks == $past(desc_word0[3:0]) + 5'h1; endproperty
	a_blk: assert property (p_blk) else $error("block count wrong");
	property p_clen; desc_valid |=> const_len == $past(desc_word1[31:26])
		&& const_load == ($past(desc_word1[31:26]) != 6'h0); endproperty
	a_clen: assert property (p_clen) else $error("constant length wrong");
	property p_cofs; desc_valid && desc_word1[31:26] != 0 |=> const_ofs == $past(desc_word1[25:20]); endproperty
	a_cofs: assert property (p_cofs) else $error("constant offset wrong");
	// scoreboard outputs lag a state write by two edges: word latch, then gated copy
	property p_sben; sb_wr ##1 (!state_we && !ptr_load)
		|=> sb_enable == (ext_seen && $past(state_wdata[31], 2)); endproperty
	a_sben: assert property (p_sben) else $error("scoreboard enable wrong");
	property p_sbf; sb_wr && state_wdata[31] ##1 (!state_we && !ptr_load && ext_seen)
		|=> sb_mask == $past(state_wdata[7:0], 2)
		&& sb_nonstall == $past(state_wdata[30], 2); endproperty
	a_sbf: assert property (p_sbf) else $error("scoreboard fields wrong");
	property p_dlt; state_we && state_addr == 3'h5 && !ptr_load ##1 (!state_we && !ptr_load && sb_enable)
		|=> sb_deltas[31:0] == $past(state_wdata, 2); endproperty
	a_dlt: assert property (p_dlt) else $error("deltas wrong");
	c_big: cover property (cmd_valid && cmd_desc_ofs > 15);
	c_sb: cover property (sb_wr && state_wdata[31]);
	c_nold: cover property (desc_valid && desc_word1[31:26] == 0);
endmodule
bind mesd_decode mesd_props #(.OFS_W(OFS_W)) u_props (.mclk, .rstn, .ptr_load, .ext_state_en,
	.state_we, .state_addr,
	.state_wdata, .cmd_valid, .cmd_desc_ofs, .desc_valid, .desc_word0, .desc_word1, .disp_valid,
	.disp_desc_idx, .sb_enable, .sb_nonstall, .sb_mask, .sb_deltas, .kern_valid, .kern_start,
	.kern_blocks, .const_load, .const_len, .const_ofs);
`default_nettype wire
